// *** verilog/lin_div_pkg.sv ***
// constants and types for the lin slave divider and header length block
package lin_div_pkg;
  // ********************
  // register byte offsets
  // ********************
  localparam logic [7:0] BAUD_RATE_OFFSET   = 8'h00;
  localparam logic [7:0] LIN_CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] EXT_RX_PRESC_OFFSET = 8'h08;
  localparam logic [7:0] EXT_TX_PRESC_OFFSET = 8'h0C;

  // ********************
  // control register fields
  // ********************
  localparam int LIN_ENABLE_BIT   = 6;
  localparam int LIN_SLAVE_BIT    = 5;
  localparam int AUTO_SYNC_BIT    = 4;
  localparam int HEADER_METHOD_BIT = 3;
  localparam logic [7:0] LIN_CONTROL_MASK = 8'h78;

  // ********************
  // reset values and field sizes
  // ********************
  localparam logic [7:0] REG_RESET          = 8'h00;
  localparam logic [3:0] FRACTION_RESET     = 4'h0;
  localparam logic [7:0] HEADER_LEN_ALL_ONES = 8'hFF;
  localparam logic [7:0] HEADER_LEN_TIMEOUT = 8'h00;
  localparam logic [7:0] MANTISSA_OFF       = 8'h00;

  // ********************
  // header timing
  // ********************
  localparam int HEADER_MAX_BITS     = 57;
  localparam int QUARTERS_PER_BIT    = 4;
  localparam int TICKS_PER_BIT       = 16;
  localparam int TICKS_PER_QUARTER   = TICKS_PER_BIT / QUARTERS_PER_BIT;
  localparam int BREAK_DETECT_BITS   = 11;
  localparam logic [7:0] HEADER_MAX_QUARTERS =
    8'(HEADER_MAX_BITS * QUARTERS_PER_BIT);
  localparam logic [7:0] BREAK_QUARTERS =
    8'(BREAK_DETECT_BITS * QUARTERS_PER_BIT);

  // events from the rest of the serial interface
  typedef struct packed {
    logic synch_break;
    logic header_timeout;
    logic header_detected;
  } header_events_t;

  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b01,
    MEAS_RUN  = 2'b10
  } meas_state_t;
endpackage

// *** verilog/lin_divider_header_length.sv ***
// lin slave fractional baud divisor and header length measurement
`timescale 1ns/1ps
// Operation
// (RL1) integer divisor part comes straight from the 8-bit mantissa register
// (RL2) slave mode with mantissa zero stops transmit and receive clocks
// (RL3) fraction register low four bits add sixteenths to the divisor
// (RL4) software keeps fraction register upper four bits at zero
// (RL5) fraction written first; mantissa write loads whole divisor into generator
// (RL6) slave mode maps mantissa on baud address, fraction on tx prescaler address
// (RL7) software never uses bit set or clear on divisor registers
// (RL8) header length visible on rx prescaler address only with auto sync or id
// (RL9) header length is read-only, changed only by hardware
// (RL10) each synch break loads header length with all ones
// (RL11) header timeout loads header length with zero
// (RL12) successful header loads measured code with the header-detected flag
// (RL13) code is 57 minus header bit times, integer high, fraction low
// (RL14) software carries a rounded sixteen sixteenths into the mantissa
// (RL15) mode bits: 0x off, 10 master, 11 slave; slave enables divisor
// (RL16) auto sync enable switches auto sync unit, slave mode only
// (RL17) method bit selects break detection or identifier detection in slave
// (RL18) two low code bits count quarter bit times
// (RL19) sixteenth accumulator makes average period equal mantissa plus fraction
module lin_divider_header_length
(
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic                                pready,
  output logic [31:0]                         prdata,
  output logic                                pslverr,
  input  wire lin_div_pkg::header_events_t    header_events,
  output logic                                lin_slave_select,
  output logic                                auto_sync_enable,
  output logic                                header_method_select,
  output logic [7:0]                          baud_rate_reg,
  output logic [7:0]                          ext_tx_prescaler_reg,
  output logic [7:0]                          ext_rx_prescaler_reg,
  output logic                                oversample_tick,
  output logic                                lin_clk_enable
);
  // ********************
  // bus decode
  // ********************
  logic        wr_en;
  logic        mapped;
  logic        lin_mode_slave;
  logic [7:0]  control_reg;
  logic [7:0]  divisor_mantissa_reg;
  logic [3:0]  divisor_fraction_reg;
  logic [7:0]  header_length_reg;
  logic [7:0]  active_mantissa_reg;
  logic [3:0]  active_fraction_reg;
  logic        header_visible;

  assign wr_en   = psel && penable && pwrite;
  assign mapped  = (paddr == lin_div_pkg::BAUD_RATE_OFFSET) ||
                   (paddr == lin_div_pkg::LIN_CONTROL_OFFSET) ||
                   (paddr == lin_div_pkg::EXT_RX_PRESC_OFFSET) ||
                   (paddr == lin_div_pkg::EXT_TX_PRESC_OFFSET);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // mode 0x off, 10 master, 11 slave
  assign lin_mode_slave = control_reg[lin_div_pkg::LIN_ENABLE_BIT] &&
                          control_reg[lin_div_pkg::LIN_SLAVE_BIT]; // [RL15]
  assign lin_slave_select     = lin_mode_slave;
  assign auto_sync_enable     = lin_mode_slave &&
                                control_reg[lin_div_pkg::AUTO_SYNC_BIT]; // [RL16]
  assign header_method_select = lin_mode_slave &&
                                control_reg[lin_div_pkg::HEADER_METHOD_BIT]; // [RL17]
  assign header_visible = auto_sync_enable || header_method_select; // [RL8]

  // ********************
  // control register
  // ********************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      control_reg <= lin_div_pkg::REG_RESET;
    else if (wr_en && paddr == lin_div_pkg::LIN_CONTROL_OFFSET)
      control_reg <= pwdata[7:0] & lin_div_pkg::LIN_CONTROL_MASK;
  end

  // ********************
  // shared addresses: normal registers or divisor
  // ********************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      baud_rate_reg        <= lin_div_pkg::REG_RESET;
      ext_tx_prescaler_reg <= lin_div_pkg::REG_RESET;
      ext_rx_prescaler_reg <= lin_div_pkg::REG_RESET;
    end
    else if (wr_en && !lin_mode_slave)
    begin
      if (paddr == lin_div_pkg::BAUD_RATE_OFFSET)
        baud_rate_reg <= pwdata[7:0];
      if (paddr == lin_div_pkg::EXT_TX_PRESC_OFFSET)
        ext_tx_prescaler_reg <= pwdata[7:0];
      if (paddr == lin_div_pkg::EXT_RX_PRESC_OFFSET)
        ext_rx_prescaler_reg <= pwdata[7:0];
    end
  end

  // mantissa on baud address, fraction on tx prescaler address
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      divisor_mantissa_reg <= lin_div_pkg::REG_RESET;
      divisor_fraction_reg <= lin_div_pkg::FRACTION_RESET;
    end
    else if (wr_en && lin_mode_slave)
    begin
      if (paddr == lin_div_pkg::BAUD_RATE_OFFSET)
        divisor_mantissa_reg <= pwdata[7:0]; // [RL6] [RL1]
      if (paddr == lin_div_pkg::EXT_TX_PRESC_OFFSET)
        divisor_fraction_reg <= pwdata[3:0]; // [RL6] [RL3]
    end
  end

  // mantissa write commits the whole divisor to the generator
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      active_mantissa_reg <= lin_div_pkg::REG_RESET;
      active_fraction_reg <= lin_div_pkg::FRACTION_RESET;
    end
    else if (wr_en && lin_mode_slave && paddr == lin_div_pkg::BAUD_RATE_OFFSET)
    begin
      active_mantissa_reg <= pwdata[7:0]; // [RL5]
      active_fraction_reg <= divisor_fraction_reg; // [RL5]
    end
  end

  // ********************
  // read mux
  // ********************
  always_comb
  begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      lin_div_pkg::BAUD_RATE_OFFSET:
        prdata[7:0] = lin_mode_slave ? divisor_mantissa_reg : baud_rate_reg;
      lin_div_pkg::LIN_CONTROL_OFFSET:
        prdata[7:0] = control_reg;
      lin_div_pkg::EXT_TX_PRESC_OFFSET:
        prdata[7:0] = lin_mode_slave ? {4'h0, divisor_fraction_reg}
                                     : ext_tx_prescaler_reg;
      lin_div_pkg::EXT_RX_PRESC_OFFSET:
        if (lin_mode_slave)
          prdata[7:0] = header_visible ? header_length_reg : 8'h00; // [RL8]
        else
          prdata[7:0] = ext_rx_prescaler_reg;
      default:
        prdata = 32'h0000_0000;
    endcase
  end

  // ********************
  // fractional baud generator
  // ********************
  logic [7:0] period_cnt_reg;
  logic [3:0] frac_acc_reg;
  logic       extra_pending_reg;
  logic [4:0] acc_sum;

  assign lin_clk_enable = !(lin_mode_slave &&
                            active_mantissa_reg == lin_div_pkg::MANTISSA_OFF); // [RL2]
  assign acc_sum = {1'b0, frac_acc_reg} + {1'b0, active_fraction_reg};

  // mantissa cycles per tick, one extra when the sixteenths carry
  always_ff @(posedge clk)
  begin
    if (sys_rst || !lin_mode_slave || !lin_clk_enable)
    begin
      period_cnt_reg    <= 8'h01;
      frac_acc_reg      <= 4'h0;
      extra_pending_reg <= 1'b0;
      oversample_tick   <= 1'b0;
    end
    else if (period_cnt_reg > 8'h01)
    begin
      period_cnt_reg  <= period_cnt_reg - 8'h01;
      oversample_tick <= 1'b0;
    end
    else if (extra_pending_reg)
    begin
      extra_pending_reg <= 1'b0;
      oversample_tick   <= 1'b0;
    end
    else
    begin
      oversample_tick   <= 1'b1;
      period_cnt_reg    <= active_mantissa_reg; // [RL1] [RL19]
      frac_acc_reg      <= acc_sum[3:0]; // [RL19]
      extra_pending_reg <= acc_sum[4]; // [RL3] [RL19]
    end
  end

  // ********************
  // header length measurement
  // ********************
  lin_div_pkg::meas_state_t meas_state_reg;
  logic [7:0] remaining_reg;
  logic [1:0] quarter_tick_reg;

  // remaining quarters of the allowed header, counted down from 57 less the 11 break bits
  always_ff @(posedge clk)
  begin
    if (sys_rst || !lin_mode_slave)
    begin
      meas_state_reg   <= lin_div_pkg::MEAS_IDLE;
      remaining_reg    <= 8'h00;
      quarter_tick_reg <= 2'b00;
    end
    else if (header_events.synch_break)
    begin
      meas_state_reg   <= lin_div_pkg::MEAS_RUN;
      remaining_reg    <= lin_div_pkg::HEADER_MAX_QUARTERS -
                          lin_div_pkg::BREAK_QUARTERS; // [RL13]
      quarter_tick_reg <= 2'b00;
    end
    else
    begin
      unique case (meas_state_reg)
        lin_div_pkg::MEAS_IDLE:
          remaining_reg <= remaining_reg;
        lin_div_pkg::MEAS_RUN:
          if (header_events.header_detected || header_events.header_timeout ||
              remaining_reg == 8'h00)
            meas_state_reg <= lin_div_pkg::MEAS_IDLE;
          else if (oversample_tick)
          begin
            quarter_tick_reg <= quarter_tick_reg + 2'b01;
            if (quarter_tick_reg == 2'(lin_div_pkg::TICKS_PER_QUARTER - 1))
              remaining_reg <= remaining_reg - 8'h01; // [RL18]
          end
        default:
          meas_state_reg <= lin_div_pkg::MEAS_IDLE;
      endcase
    end
  end

  // only hardware events change the header length
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      header_length_reg <= lin_div_pkg::REG_RESET;
    else if (header_events.synch_break)
      header_length_reg <= lin_div_pkg::HEADER_LEN_ALL_ONES; // [RL10] [RL9]
    else if (header_events.header_timeout ||
             (meas_state_reg == lin_div_pkg::MEAS_RUN && remaining_reg == 8'h00
              && !header_events.header_detected))
      header_length_reg <= lin_div_pkg::HEADER_LEN_TIMEOUT; // [RL11]
    else if (header_events.header_detected &&
             meas_state_reg == lin_div_pkg::MEAS_RUN)
      header_length_reg <= remaining_reg; // [RL12] [RL13] [RL18]
  end
endmodule

// *** tb/lin_div_asserts.sv ***
// port assertions for the lin divider and header length block
`timescale 1ns/1ps
module lin_div_asserts
(
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic [31:0]                 prdata,
  input wire lin_div_pkg::header_events_t header_events,
  input wire logic                        lin_slave_select,
  input wire logic                        auto_sync_enable,
  input wire logic                        header_method_select,
  input wire logic [7:0]                  baud_rate_reg,
  input wire logic                        oversample_tick,
  input wire logic                        lin_clk_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic rd_rx;
  logic rd_hl;
  assign rd_rx = psel && penable && !pwrite && paddr == lin_div_pkg::EXT_RX_PRESC_OFFSET;
  assign rd_hl = rd_rx && lin_slave_select && (auto_sync_enable || header_method_select);

  a_clk_stop: assert property (lin_slave_select && !lin_clk_enable |-> !oversample_tick)
    else $error("tick while clocks stopped");
  a_clk_on: assert property (!$past(lin_slave_select) && !lin_slave_select |->
    lin_clk_enable && !oversample_tick) else $error("generator active outside slave");
  a_mode_bits: assert property (!lin_slave_select |->
    !auto_sync_enable && !header_method_select) else $error("mode bit outside slave");
  a_hl_hidden: assert property (rd_rx && lin_slave_select && !auto_sync_enable
    && !header_method_select |-> prdata == 32'h0) else $error("hidden length not zero");
  a_frac_upper: assert property (psel && penable && !pwrite && lin_slave_select
    && paddr == lin_div_pkg::EXT_TX_PRESC_OFFSET |-> prdata[31:4] == 28'h0)
    else $error("fraction upper bits set");
  a_break_ones: assert property (rd_hl && $past(header_events.synch_break)
    && $past(lin_slave_select) |-> prdata == 32'h0000_00FF) else $error("break not FF");
  a_timeout_zero: assert property (rd_hl && $past(header_events.header_timeout)
    && !$past(header_events.synch_break) && $past(lin_slave_select) |-> prdata == 32'h0)
    else $error("timeout not zero");
  a_baud_kept: assert property (psel && penable && pwrite && lin_slave_select
    && paddr == lin_div_pkg::BAUD_RATE_OFFSET |=> $stable(baud_rate_reg))
    else $error("baud register changed in slave");
endmodule
bind lin_divider_header_length lin_div_asserts chk_u
(
  .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata, .header_events,
  .lin_slave_select, .auto_sync_enable, .header_method_select, .baud_rate_reg,
  .oversample_tick, .lin_clk_enable
);

// *** tb/lin_master_model.sv ***
// lin master model issuing one-cycle header events
`timescale 1ns/1ps
module lin_master_model
(
  input  wire logic                   clk,
  output lin_div_pkg::header_events_t header_events
);
  initial header_events = '0;
  // kind bits: break, timeout, detected
  task automatic send(input logic [2:0] kind);
    @(posedge clk);
    header_events <= kind;
    @(posedge clk);
    header_events <= '0;
  endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench for the lin divider and header length block
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] BAUD = lin_div_pkg::BAUD_RATE_OFFSET;
  localparam logic [7:0] CTRL = lin_div_pkg::LIN_CONTROL_OFFSET;
  localparam logic [7:0] RX   = lin_div_pkg::EXT_RX_PRESC_OFFSET;
  localparam logic [7:0] TX   = lin_div_pkg::EXT_TX_PRESC_OFFSET;
  logic                        clk = 1'h0;
  logic                        sys_rst = 1'h1;
  logic                        psel = 1'h0;
  logic                        penable = 1'h0;
  logic                        pwrite = 1'h0;
  logic [7:0]                  paddr = 8'h00;
  logic [31:0]                 pwdata = 32'h0;
  logic                        pready, pslverr, lin_slave_select, auto_sync_enable;
  logic                        header_method_select, oversample_tick, lin_clk_enable;
  logic [31:0]                 prdata, rdata;
  logic [7:0]                  baud_rate_reg, ext_tx_prescaler_reg;
  logic                        rerr;
  lin_div_pkg::header_events_t header_events;
  int                          bad_count = 0;
  int                          n_checks = 0;
  int                          tick_cnt = 0;
  int                          t0, k;
  logic [7:0]                  mode_tab [6] = '{8'h00, 8'h20, 8'h40, 8'h58, 8'h70, 8'h68};

  always #4 clk = ~clk;
  always @(posedge clk) if (oversample_tick === 1'h1) tick_cnt <= tick_cnt + 1;

  lin_divider_header_length dut_u
  (
    .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .header_events, .lin_slave_select, .auto_sync_enable, .header_method_select,
    .baud_rate_reg, .ext_tx_prescaler_reg, .ext_rx_prescaler_reg(), .oversample_tick,
    .lin_clk_enable
  );
  lin_master_model lm_u (.clk, .header_events);

  // ********************
  // bus, compare, tick counting and closing tasks
  // ********************
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one step of slack for counts sampled across a tick boundary
  task automatic check_near(input logic [31:0] got, input int exp);
    n_checks++;
    if (^got === 1'hX || int'(got) < exp - 1 || int'(got) > exp + 1)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic ticks_in(input int n);
    t0 = tick_cnt;
    repeat (n) @(posedge clk);
    k = tick_cnt - t0;
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    for (int a = 0; a < 16; a += 4)
    begin
      apb(1'h0, 8'(a), 32'h0);
      check_eq(rdata, 32'h0);
      check_eq(rerr, 1'h0);
    end
    check_eq(lin_clk_enable, 1'h1);
  endtask
  task automatic t_modes();
    logic slv;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'h1, CTRL, {24'h0, mode_tab[i]});
      @(posedge clk);
      slv = mode_tab[i][6] & mode_tab[i][5];
      check_eq(lin_slave_select, slv);
      check_eq(auto_sync_enable, mode_tab[i][4] & slv);
      check_eq(header_method_select, mode_tab[i][3] & slv);
    end
  endtask
  task automatic t_normal();
    apb(1'h1, CTRL, 32'h0);
    apb(1'h1, BAUD, 32'h5A);
    apb(1'h1, TX, 32'hA5);
    @(posedge clk);
    check_eq(baud_rate_reg, 8'h5A);
    check_eq(ext_tx_prescaler_reg, 8'hA5);
    apb(1'h0, 8'h10, 32'h0);
    check_eq(rerr, 1'h1);
    check_eq(rdata, 32'h0);
  endtask
  task automatic t_divisor();
    apb(1'h1, CTRL, 32'h60);
    apb(1'h1, TX, 32'h0A);
    apb(1'h0, TX, 32'h0);
    check_eq(rdata, 32'hA);
    apb(1'h1, BAUD, 32'h0);
    ticks_in(64);
    check_eq(lin_clk_enable, 1'h0);
    check_eq(k, 0);
    apb(1'h1, TX, 32'h5);
    apb(1'h1, BAUD, 32'h3);
    ticks_in(212);
    check_near(k, 64);
    apb(1'h0, BAUD, 32'h0);
    check_eq(rdata, 32'h3);
    check_eq(baud_rate_reg, 8'h5A);
    apb(1'h1, TX, 32'h0);
    ticks_in(212);
    check_near(k, 64);
    // divisor 3.97: fraction rounds to sixteen, carried into the mantissa
    apb(1'h1, BAUD, 32'h4);
    ticks_in(200);
    check_near(k, 50);
  endtask
  task automatic t_header();
    apb(1'h1, BAUD, 32'h1);
    apb(1'h1, CTRL, 32'h70);
    fork
      lm_u.send(3'h4);
      apb(1'h0, RX, 32'h0);
    join
    t0 = tick_cnt;
    check_eq(rdata, 32'hFF);
    repeat (40) @(posedge clk);
    k = 184 - (tick_cnt - t0) / 4;
    fork
      lm_u.send(3'h1);
      apb(1'h0, RX, 32'h0);
    join
    check_near(rdata, k);
    apb(1'h1, RX, 32'h12);
    apb(1'h0, RX, 32'h0);
    check_near(rdata, k);
    fork
      lm_u.send(3'h2);
      apb(1'h0, RX, 32'h0);
    join
    check_eq(rdata, 32'h0);
    apb(1'h1, CTRL, 32'h68);
    fork
      lm_u.send(3'h4);
      apb(1'h0, RX, 32'h0);
    join
    check_eq(rdata, 32'hFF);
    apb(1'h1, CTRL, 32'h60);
    apb(1'h0, RX, 32'h0);
    check_eq(rdata, 32'h0);
    apb(1'h1, CTRL, 32'h68);
    repeat (800) @(posedge clk);
    apb(1'h0, RX, 32'h0);
    check_eq(rdata, 32'h0);
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    t_reset();
    t_modes();
    t_normal();
    t_divisor();
    t_header();
    close_out();
  end
  initial
  begin
    #200000;
    bad_count++;
    close_out();
  end
endmodule
